// File: pcfg_pkg.sv
// Package of constants for the port 1 and pin 2.0 configuration block.
`default_nettype none
package pcfg_pkg;
  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_P1_MODE_LO   = 8'hB3;
  localparam logic [7:0] IDX_P1_MODE_HI   = 8'hB4;
  localparam logic [7:0] IDX_P20_SETTING  = 8'hB5;
  localparam logic [7:0] IDX_PAGE_SELECT  = 8'hC0;
  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_P1_MODE_LO   = 8'hFF;
  localparam logic [7:0] RST_P1_MODE_HI   = 8'h00;
  localparam logic [7:0] RST_P1_THRESH    = 8'h00;
  localparam logic [7:0] RST_P1_SLEW      = 8'h00;
  localparam logic [7:0] RST_P20_SETTING  = 8'h00;
  // ------------------------------------------------------------------
  // Field positions of the pin 2.0 setting register
  // ------------------------------------------------------------------
  localparam int BIT_P20_PULLUP   = 7;
  localparam int BIT_T1_OUT_EN    = 3;
  localparam int BIT_T0_OUT_EN    = 2;
  localparam int BIT_P20_SCHMITT  = 0;
  localparam logic [7:0] MASK_P20_SETTING = 8'h8D;
  // ------------------------------------------------------------------
  // Pin modes, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    PCFG_MODE_QUASI = 4'h1,
    PCFG_MODE_PUSH  = 4'h2,
    PCFG_MODE_INPUT = 4'h4,
    PCFG_MODE_OPEN  = 4'h8
  } pcfg_mode_t;
endpackage
`default_nettype wire

// File: pcfg_mode_decode.sv
// Decoder of the two mode bits of one pin into a one-hot pad mode.
`default_nettype none
module pcfg_mode_decode (
  input  wire logic       mode_lo,
  input  wire logic       mode_hi,
  output var  logic [3:0] mode_onehot
);
  always_comb begin
    case ({mode_lo, mode_hi})
      2'b00:   mode_onehot = pcfg_pkg::PCFG_MODE_QUASI;
      2'b01:   mode_onehot = pcfg_pkg::PCFG_MODE_PUSH;
      2'b10:   mode_onehot = pcfg_pkg::PCFG_MODE_INPUT;
      2'b11:   mode_onehot = pcfg_pkg::PCFG_MODE_OPEN;
      default: mode_onehot = pcfg_pkg::PCFG_MODE_INPUT;
    endcase
  end
endmodule
`default_nettype wire

// File: pcfg_p20_pull.sv
// Pull-up resolver for pin 2.0 under the reset-pin option.
`default_nettype none
module pcfg_p20_pull (
  input  wire logic sw_pullup,
  input  wire logic reset_pin_disable_option,
  output var  logic pullup_on
);
  // dedicated function forces pull-up on
  // Option one gives the pin to its dedicated function.
  always_comb begin
    pullup_on = reset_pin_disable_option ? 1'b1 : sw_pullup;
  end
endmodule
`default_nettype wire

// File: pcfg_top.sv
// Port 1 and pin 2.0 configuration registers with an Avalon-MM slave.
//
// Behaviour
// - mode low and high bits pick pin mode.
// - 00 quasi, 01 push, 10 input, 11 open.
// - mode high register B4H page 0, reset zero.
// - threshold bits B3H page 1, one Schmitt.
// - slew bits B4H page 1, one fast.
// - bit 7 pull-up, only when option zero.
// - dedicated pin function keeps pull-up enabled.
// - bit 3 routes timer 1 output out.
// - bit 2 routes timer 0 output out.
// - bit 0 selects pin 2.0 threshold.
// - setting register B5H any page, reset zero.
//
// Our own choice: register access over Avalon-MM.
`default_nettype none
module pcfg_top #(
  parameter int PINS = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [31:0]       avs_readdata,
  output var  logic              avs_waitrequest,
  output var  logic [1:0]        avs_response,
  input  wire logic              reset_pin_disable_option,
  input  wire logic              timer0_out,
  input  wire logic              timer1_out,
  output var  logic [4*PINS-1:0] p1_mode_onehot,
  output var  logic [PINS-1:0]   p1_schmitt_sel,
  output var  logic [PINS-1:0]   p1_fast_slew,
  output var  logic              pin20_pullup_on,
  output var  logic              pin20_schmitt_sel,
  output var  logic              timer0_pin_out,
  output var  logic              timer0_pin_oe_n,
  output var  logic              timer1_pin_out,
  output var  logic              timer1_pin_oe_n,
  output var  logic              page_sel
);
  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  if (PINS != 8) begin : g_bad_pins
    $error("pcfg_top: PINS must be 8");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  mode_lo;
    logic [7:0]  mode_hi;
    logic [7:0]  thresh;
    logic [7:0]  slew;
    logic [7:0]  p20set;
    logic        page;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  resp;
  } pcfg_state_t;

  pcfg_state_t s_q;
  pcfg_state_t s_d;

  logic [7:0] idx;
  logic       hit;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign idx   = avs_address[9:2];
  assign wbyte = avs_writedata[7:0];

  // ------------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------------
  // One wait cycle: the request is answered the cycle after it appears,
  // which keeps read data coming straight from flip-flops.
  always_comb begin
    s_d   = s_q;
    hit   = 1'b1;
    rbyte = 8'h00;
    s_d.ack = 1'b0;
    case (idx)
      // threshold shares address on page 1
      pcfg_pkg::IDX_P1_MODE_LO:  rbyte = s_q.page ? s_q.thresh : s_q.mode_lo;
      // slew shares address on page 1
      pcfg_pkg::IDX_P1_MODE_HI:  rbyte = s_q.page ? s_q.slew : s_q.mode_hi;
      pcfg_pkg::IDX_P20_SETTING: rbyte = s_q.p20set;
      pcfg_pkg::IDX_PAGE_SELECT: rbyte = {7'h00, s_q.page};
      default:                   hit   = 1'b0;
    endcase
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack   = 1'b1;
      s_d.resp  = hit ? 2'b00 : 2'b10;
      s_d.rdata = avs_read ? {24'h000000, rbyte} : 32'h00000000;
      if (avs_write && hit && avs_byteenable[0]) begin
        case (idx)
          pcfg_pkg::IDX_P1_MODE_LO: begin
            if (s_q.page) begin
              s_d.thresh = wbyte;
            end else begin
              s_d.mode_lo = wbyte;
            end
          end
          pcfg_pkg::IDX_P1_MODE_HI: begin
            if (s_q.page) begin
              s_d.slew = wbyte;
            end else begin
              s_d.mode_hi = wbyte;
            end
          end
          pcfg_pkg::IDX_P20_SETTING: begin
            s_d.p20set = wbyte & pcfg_pkg::MASK_P20_SETTING;
          end
          pcfg_pkg::IDX_PAGE_SELECT: s_d.page = wbyte[0];
          default:                   s_d.page = s_q.page;
        endcase
      end
    end
    if (rst) begin
      s_d.mode_lo = pcfg_pkg::RST_P1_MODE_LO;
      s_d.mode_hi = pcfg_pkg::RST_P1_MODE_HI;
      s_d.thresh  = pcfg_pkg::RST_P1_THRESH;
      s_d.slew    = pcfg_pkg::RST_P1_SLEW;
      s_d.p20set  = pcfg_pkg::RST_P20_SETTING;
      s_d.page    = 1'b0;
      s_d.ack     = 1'b0;
      s_d.rdata   = 32'h00000000;
      s_d.resp    = 2'b00;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign avs_response    = s_q.resp;
  assign page_sel        = s_q.page;

  // ------------------------------------------------------------------
  // Pad controls
  // ------------------------------------------------------------------
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    pcfg_mode_decode u_dec (
      .mode_lo     (s_q.mode_lo[i]),
      .mode_hi     (s_q.mode_hi[i]),
      .mode_onehot (p1_mode_onehot[4*i+3:4*i])
    );
  end

  assign p1_schmitt_sel = s_q.thresh;
  assign p1_fast_slew   = s_q.slew;

  pcfg_p20_pull u_pull (
    .sw_pullup                (s_q.p20set[pcfg_pkg::BIT_P20_PULLUP]),
    .reset_pin_disable_option (reset_pin_disable_option),
    .pullup_on                (pin20_pullup_on)
  );

  assign pin20_schmitt_sel = s_q.p20set[pcfg_pkg::BIT_P20_SCHMITT];

  assign timer0_pin_out  = timer0_out;
  assign timer0_pin_oe_n = !s_q.p20set[pcfg_pkg::BIT_T0_OUT_EN];
  assign timer1_pin_out  = timer1_out;
  assign timer1_pin_oe_n = !s_q.p20set[pcfg_pkg::BIT_T1_OUT_EN];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // A request is taken at the edge where waitrequest is still high, so the
  // registers and the answer both change at that same edge.
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence done_s;
    !avs_waitrequest;
  endsequence
  sequence wr_take_s;
    avs_write && avs_waitrequest && avs_byteenable[0];
  endsequence
  sequence rd_take_s;
    avs_read && avs_waitrequest;
  endsequence

  a_bus_answer_one: assert property (@(posedge clk) disable iff (rst)
    req_s |=> done_s)
    else $error("bus answer not one cycle later");

  a_reset_mode_input: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> p1_mode_onehot == {PINS{pcfg_pkg::PCFG_MODE_INPUT}})
    else $error("pins not input-only after reset");

  a_reset_thresh: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> (p1_schmitt_sel == 8'h00) && (p1_fast_slew == 8'h00))
    else $error("threshold or slew not zero after reset");

  a_reset_setting: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> (s_q.p20set == pcfg_pkg::RST_P20_SETTING) && !page_sel
      && timer0_pin_oe_n && timer1_pin_oe_n)
    else $error("setting register not clear after reset");

  a_mode_pair_decode: assert property (@(posedge clk) disable iff (rst)
    (s_q.mode_lo[0] && s_q.mode_hi[0]) |->
      p1_mode_onehot[3:0] == pcfg_pkg::PCFG_MODE_OPEN)
    else $error("pin 0 open-drain decode wrong");

  a_mode_push_pin7: assert property (@(posedge clk) disable iff (rst)
    (!s_q.mode_lo[7] && s_q.mode_hi[7]) |->
      p1_mode_onehot[31:28] == pcfg_pkg::PCFG_MODE_PUSH)
    else $error("pin 7 push-pull decode wrong");

  a_mode_quasi_pin3: assert property (@(posedge clk) disable iff (rst)
    (!s_q.mode_lo[3] && !s_q.mode_hi[3]) |->
      p1_mode_onehot[15:12] == pcfg_pkg::PCFG_MODE_QUASI)
    else $error("pin 3 quasi-bidirectional decode wrong");

  a_mode_input_pin5: assert property (@(posedge clk) disable iff (rst)
    (s_q.mode_lo[5] && !s_q.mode_hi[5]) |->
      p1_mode_onehot[23:20] == pcfg_pkg::PCFG_MODE_INPUT)
    else $error("pin 5 input-only decode wrong");

  a_page0_low_wr: assert property (@(posedge clk) disable iff (rst)
    (wr_take_s ##0 (!s_q.page && idx == pcfg_pkg::IDX_P1_MODE_LO)) |=>
      (s_q.mode_lo == $past(wbyte)) && $stable(s_q.thresh))
    else $error("page 0 write missed mode low bits");

  a_page1_thresh_wr: assert property (@(posedge clk) disable iff (rst)
    (wr_take_s ##0 (s_q.page && idx == pcfg_pkg::IDX_P1_MODE_LO)) |=>
      (p1_schmitt_sel == $past(wbyte)) && $stable(s_q.mode_lo))
    else $error("page 1 write missed threshold");

  a_page0_high_wr: assert property (@(posedge clk) disable iff (rst)
    (wr_take_s ##0 (!s_q.page && idx == pcfg_pkg::IDX_P1_MODE_HI)) |=>
      (s_q.mode_hi == $past(wbyte)) && $stable(s_q.slew))
    else $error("page 0 write missed mode high bits");

  a_slew_page_wr: assert property (@(posedge clk) disable iff (rst)
    (wr_take_s ##0 (s_q.page && idx == pcfg_pkg::IDX_P1_MODE_HI)) |=>
      (p1_fast_slew == $past(wbyte)) && $stable(s_q.mode_hi))
    else $error("slew write lost");

  a_be_low_ignored: assert property (@(posedge clk) disable iff (rst)
    (req_s ##0 (avs_write && !avs_byteenable[0])) |=>
      $stable(s_q.mode_lo) && $stable(s_q.mode_hi) && $stable(s_q.p20set))
    else $error("write without low byte lane stored");

  a_page_steer_rd: assert property (@(posedge clk) disable iff (rst)
    (rd_take_s ##0 (s_q.page && idx == pcfg_pkg::IDX_P1_MODE_LO)) |=>
      avs_readdata == {24'h000000, $past(s_q.thresh)})
    else $error("page 1 read did not return threshold");

  a_page0_high_rd: assert property (@(posedge clk) disable iff (rst)
    (rd_take_s ##0 (!s_q.page && idx == pcfg_pkg::IDX_P1_MODE_HI)) |=>
      avs_readdata == {24'h000000, $past(s_q.mode_hi)})
    else $error("page 0 read did not return mode high bits");

  a_unmapped_refused: assert property (@(posedge clk) disable iff (rst)
    (req_s ##0 !hit) |=> (avs_response == 2'b10)
      && (avs_readdata == 32'h00000000))
    else $error("unmapped access not refused");

  a_pullup_forced: assert property (@(posedge clk) disable iff (rst)
    reset_pin_disable_option |-> pin20_pullup_on)
    else $error("dedicated pin pull-up off");

  a_pullup_soft: assert property (@(posedge clk) disable iff (rst)
    !reset_pin_disable_option |->
      pin20_pullup_on == s_q.p20set[7])
    else $error("software pull-up not followed");

  a_t0_route: assert property (@(posedge clk) disable iff (rst)
    timer0_pin_oe_n == !s_q.p20set[2])
    else $error("timer 0 enable wrong");

  a_t1_route: assert property (@(posedge clk) disable iff (rst)
    !timer1_pin_oe_n |-> s_q.p20set[3])
    else $error("timer 1 enable wrong");

  a_t1_copy: assert property (@(posedge clk) disable iff (rst)
    !timer1_pin_oe_n |-> timer1_pin_out == timer1_out)
    else $error("timer 1 pin does not follow timer");

  a_setting_unimpl: assert property (@(posedge clk) disable iff (rst)
    (s_q.p20set & ~pcfg_pkg::MASK_P20_SETTING) == 8'h00)
    else $error("unimplemented setting bits set");

  a_schmitt_p20: assert property (@(posedge clk) disable iff (rst)
    pin20_schmitt_sel == s_q.p20set[0])
    else $error("pin 2.0 threshold wrong");
endmodule
`default_nettype wire

// File: pcfg_pad_model.sv
// Pad model: timer sources and the two timer pins as seen outside.
`default_nettype none
module pcfg_pad_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic t0_drv,
  input  wire logic t0_oe_n,
  input  wire logic t1_drv,
  input  wire logic t1_oe_n,
  output var  logic timer0_out,
  output var  logic timer1_out,
  output var  logic timer0_pin,
  output var  logic timer1_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic       l0_q;
  logic       l1_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
    if (!t0_oe_n) l0_q <= t0_drv;
    if (!t1_oe_n) l1_q <= t1_drv;
  end
  // timers in timer mode
  // Both sources are free-running timer outputs, never counter inputs.
  assign timer0_out = cnt_q[1];
  assign timer1_out = cnt_q[2];
  // released pins
  // A released pin has no keeper, so it shows the inverse of its last level.
  assign timer0_pin = t0_oe_n ? ~l0_q : t0_drv;
  assign timer1_pin = t1_oe_n ? ~l1_q : t1_drv;
endmodule
`default_nettype wire

// File: port1_pin_config_regs_test.sv
// Self-checking bench for the port configuration registers.
`default_nettype none
module port1_pin_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  adr = 10'h000;
  logic        rd  = 1'b0;
  logic        wr  = 1'b0;
  logic [31:0] wd  = 32'h0;
  logic [3:0]  be  = 4'hF;
  logic        opt = 1'b0;
  logic [31:0] rdat;
  logic [1:0]  resp;
  logic        wait_r;
  logic [31:0] onehot;
  logic [7:0]  sch;
  logic [7:0]  slw;
  logic        pu, s20, t0o, t1o, t0p, t1p, t0n, t1n, pg, p0, p1;
  logic [7:0]  m [0:5];
  logic [7:0]  idx_tab [0:5] = '{8'hB3, 8'hB4, 8'hB5, 8'hC0, 8'hB6, 8'h00};
  integer      seed = 32'hccd7b897;
  integer      fails = 0;
  integer      checks_done = 0;
  integer      cyc = 0;
  logic [31:0] q;
  logic [1:0]  r;
  pcfg_top pcfg_top_i (.clk(clk), .rst(rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_r),
    .avs_response(resp), .reset_pin_disable_option(opt),
    .timer0_out(t0o), .timer1_out(t1o), .p1_mode_onehot(onehot),
    .p1_schmitt_sel(sch), .p1_fast_slew(slw), .pin20_pullup_on(pu),
    .pin20_schmitt_sel(s20), .timer0_pin_out(p0), .timer0_pin_oe_n(t0n),
    .timer1_pin_out(p1), .timer1_pin_oe_n(t1n), .page_sel(pg));
  pcfg_pad_model pcfg_pad_model_i (.clk(clk), .rst(rst), .t0_drv(p0),
    .t0_oe_n(t0n), .t1_drv(p1), .t1_oe_n(t1n), .timer0_out(t0o),
    .timer1_out(t1o), .timer0_pin(t0p), .timer1_pin(t1p));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic int slot(input logic [7:0] i);
    case (i)
      8'hB3: return m[5][0] ? 1 : 0;
      8'hB4: return m[5][0] ? 3 : 2;
      8'hB5: return 4;
      8'hC0: return 5;
      default: return 6;
    endcase
  endfunction
  // Holds the request until waitrequest is seen low at a rising edge. The
  // values read at the falling edge are those that rising edge samples.
  task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d,
                     input logic [3:0] e);
    logic b;
    @(posedge clk);
    adr <= {i, 2'b00};
    wr  <= w;
    rd  <= !w;
    wd  <= {$random(seed)} & 32'hFFFFFF00 | {24'h0, d};
    be  <= e;
    do begin
      @(negedge clk);
      b = wait_r;
      q = rdat;
      r = resp;
      @(posedge clk);
    end while (b !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic outs();
    @(negedge clk);
    for (int i = 0; i < 8; i++) chk(onehot[4*i+:4], 4'h1 << {m[0][i], m[2][i]});
    chk(sch, m[1]);
    chk(slw, m[3]);
    chk(pu, opt | m[4][7]);
    chk(s20, m[4][0]);
    chk({t1n, t0n}, {~m[4][3], ~m[4][2]});
    chk({p1, p0}, {t1o, t0o});
    if (m[4][2]) chk(t0p, t0o);
    if (m[4][3]) chk(t1p, t1o);
    chk(pg, m[5][0]);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    logic [7:0] i, d;
    logic [3:0] e;
    int s;
    // Two passes: the second one starts from a reset in mid-run.
    repeat (2) begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      m = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      outs();
      // reset values on both pages and unmapped refusal
      for (int k = 0; k < 12; k++) begin
        i = idx_tab[k % 6];
        if (k == 6) begin
          acc(1'b1, 8'hC0, 8'h01, 4'hF);
          m[5] = 8'h01;
        end
        s = slot(i);
        acc(1'b0, i, 8'h00, 4'hF);
        chk(i == 8'hC0 ? q & 32'h1 : q, s < 6 ? m[s] : 8'h00);
        chk(r, s < 6 ? 2'b00 : 2'b10);
      end
      // Random writes with read-back and pad check after each.
      repeat (150) begin
        i = idx_tab[{$random(seed)} % 6];
        d = 8'($random(seed));
        e = 4'($random(seed));
        @(posedge clk);
        opt <= 1'($random(seed));
        s = slot(i);
        acc(1'b1, i, d, e);
        // writes land only where mapped and enabled
        if (e[0] && s < 6)
          m[s] = d & (s == 4 ? 8'h8D : s == 5 ? 8'h01 : 8'hFF);
        chk(r, s < 6 ? 2'b00 : 2'b10);
        s = slot(i);
        acc(1'b0, i, 8'h00, 4'hF);
        chk(i == 8'hC0 ? q & 32'h1 : q, s < 6 ? m[s] : 8'h00);
        outs();
      end
      @(posedge clk);
      rst <= 1'b1;
    end
    final_report();
  end
endmodule
`default_nettype wire
